// [logic/pdc_pkg.sv]
package pdc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_KHZ        = 25000;
  localparam int unsigned WD_FOW_US      = 3200;
  localparam int unsigned WD_FOW_CYC     = WD_FOW_US * CLK_KHZ / 1000;
  localparam int unsigned WD_RST_US      = 400;
  localparam int unsigned WD_RST_CYC     = WD_RST_US * CLK_KHZ / 1000;
  localparam int          WD_CW          = 17;
  localparam int          DT_W           = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_DEAD      = 8'h04;
  localparam logic [7:0]  ADDR_STAT      = 8'h08;
  localparam logic [7:0]  ADDR_WDOG      = 8'h0C;

  // Control word (config_word_zero) fields.
  localparam int          CB_GATE_LVL    = 0;
  localparam int          CB_HOST_5V     = 1;
  localparam int          CB_MODE3       = 2;
  localparam int          CB_WD_EN       = 3;
  localparam int          CB_SLO_PROT    = 4;
  localparam int          CB_SHI_PROT    = 5;
  localparam int          CB_BHI_HIZ     = 6;
  localparam logic [7:0]  CTRL_RST       = 8'h00;

  // Dead-time register fields; the upper OTP byte carries the minimum.
  localparam int          DB_MIN_LSB     = 0;
  localparam int          DB_DYN_LSB     = 8;
  localparam int          OTP_DT_LSB     = 8;
  localparam logic [3:0]  DT_RST         = 4'h0;

  // Status fields.
  localparam int          SB_STATE_LSB   = 0;
  localparam int          SB_SLO         = 4;
  localparam int          SB_SHI         = 5;
  localparam int          SB_BHI         = 6;
  localparam int          SB_GUV         = 7;
  localparam int          SB_WDERR       = 8;
  localparam int          SB_HRST        = 9;
  localparam int          SB_FAULT       = 10;

  //////////////////////////////////////////////////////////////////////////////
  // Synchroniser bit positions.
  localparam int          SY_WAKE        = 0;
  localparam int          SY_EN          = 1;
  localparam int          SY_HS          = 2;
  localparam int          SY_LS          = 5;
  localparam int          SY_POR         = 8;
  localparam int          SY_VCC         = 9;
  localparam int          SY_GUV         = 10;
  localparam int          SY_SLO         = 11;
  localparam int          SY_SHI         = 12;
  localparam int          SY_BHI         = 13;
  localparam int          SY_PWM         = 14;
  localparam int          NSYNC          = 15;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_POR   = 3'h1,
    ST_CFG   = 3'h3,
    ST_HOST  = 3'h2,
    ST_STBY  = 3'h6,
    ST_NORM  = 3'h7
  } pdc_state_t;

endpackage

// [logic/pdc_phase.sv]
`timescale 1ns/1ps

// One half-bridge: command decode, shoot-through blocking and dead time.
module pdc_phase (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       drive_en,
  input  wire logic       mode3,
  input  wire logic       hs_cmd,
  input  wire logic       ls_cmd,
  input  wire logic [3:0] dt_min,
  input  wire logic [3:0] dt_dyn,
  output logic            gate_hi,
  output logic            gate_lo
);

  typedef struct packed {
    logic                      hi;
    logic                      lo;
    logic [pdc_pkg::DT_W-1:0]  cnt;
  } pdc_phase_t;

  pdc_phase_t q;
  pdc_phase_t n;
  logic       want_hi;
  logic       want_lo;
  logic [3:0] dt;

  always_comb
  begin
    n       = q;
    want_hi = hs_cmd & ls_cmd;
    if (mode3)
      want_lo = ls_cmd & ~hs_cmd;
    else
      want_lo = ~hs_cmd & ~ls_cmd;
    if (!drive_en)
    begin
      want_hi = 1'b0;
      want_lo = 1'b0;
    end
    // The larger of the dynamic and minimum values is taken at the start of each dead-time interval.
    dt = (dt_dyn > dt_min) ? dt_dyn : dt_min;
    if (q.cnt != '0)
      n.cnt = q.cnt - 4'h1;
    if (q.hi && !want_hi)
    begin
      n.hi  = 1'b0;
      n.cnt = dt;
    end
    else if (!q.hi && want_hi && !q.lo && q.cnt == '0)
      n.hi = 1'b1;
    if (q.lo && !want_lo)
    begin
      n.lo  = 1'b0;
      n.cnt = dt;
    end
    else if (!q.lo && want_lo && !q.hi && q.cnt == '0)
      n.lo = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end

  assign gate_hi = q.hi;
  assign gate_lo = q.lo;

endmodule

// [logic/pdc_top.sv]
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module pdc_top #(
  parameter int unsigned WD_FOW_CYCLES = pdc_pkg::WD_FOW_CYC,
  parameter int unsigned WD_RST_CYCLES = pdc_pkg::WD_RST_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wake_in,
  input  wire logic        drive_enable_in,
  input  wire logic [2:0]  high_side_cmd_in,
  input  wire logic [2:0]  low_side_cmd_in,
  input  wire logic        core_regulator_sense,
  input  wire logic        host_supply_ok_in,
  input  wire logic        gate_supply_low_in,
  input  wire logic        supply_low_in,
  input  wire logic        supply_high_in,
  input  wire logic        bridge_supply_high_in,
  input  wire logic        high_voltage_pwm_in,
  input  wire logic [15:0] otp_cfg_in,
  output logic             core_regulator_out,
  output logic             osc_en_out,
  output logic             host_supply_en_out,
  output logic             gate_supply_rail,
  output logic             serial_port_en_out,
  output logic             host_supply_volt_select,
  output logic             gate_supply_level_select,
  output logic             host_reset_out,
  output logic             host_reset_oe_n,
  output logic             fault_indicator_out,
  output logic             fault_indicator_oe_n,
  output logic [2:0]       upper_gate_out,
  output logic [2:0]       lower_gate_out,
  output logic             gates_hiz_out,
  output logic             pwm_level_out
);

  typedef struct packed {
    logic [pdc_pkg::NSYNC-1:0]  s1;
    logic [pdc_pkg::NSYNC-1:0]  s2;
    pdc_pkg::pdc_state_t        st;
    logic [7:0]                 ctrl;
    logic [3:0]                 dt_min;
    logic [3:0]                 dt_dyn;
    logic [pdc_pkg::WD_CW-1:0]  wd_cnt;
    logic                       wd_rst;
    logic                       wd_err;
    logic                       hrst_drv;
    logic                       fault_drv;
    logic                       hiz;
    logic                       pwm;
    logic [31:0]                rdata;
    logic                       err;
  } pdc_top_t;

  pdc_top_t q;
  pdc_top_t n;

  logic [pdc_pkg::NSYNC-1:0] raw;
  logic                      wake_s;
  logic                      en_s;
  logic                      awake;
  logic                      bus_ok;
  logic                      setup;
  logic                      wr;
  logic                      rd;
  logic                      mapped;
  logic                      drive_ok;
  logic                      slo_hit;
  logic                      shi_hit;
  logic                      bhi_hit;
  logic                      guv;
  logic [31:0]               stat;

  //////////////////////////////////////////////////////////////////////////////
  // Every status and command pin and comparator is asynchronous to the clock and is read only
  // after the second flip-flop; the APB bus and the OTP word are used directly.
  assign raw = {high_voltage_pwm_in, bridge_supply_high_in, supply_high_in, supply_low_in,
                gate_supply_low_in, host_supply_ok_in, core_regulator_sense,
                low_side_cmd_in, high_side_cmd_in, drive_enable_in, wake_in};

  assign wake_s  = q.s2[pdc_pkg::SY_WAKE];
  assign en_s    = q.s2[pdc_pkg::SY_EN];
  assign awake   = (q.st == pdc_pkg::ST_STBY) || (q.st == pdc_pkg::ST_NORM);
  assign bus_ok  = awake;
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & ~q.err;
  assign rd      = psel & penable & ~pwrite & ~q.err;
  assign mapped  = (paddr == pdc_pkg::ADDR_CTRL) || (paddr == pdc_pkg::ADDR_DEAD) ||
                   (paddr == pdc_pkg::ADDR_STAT) || (paddr == pdc_pkg::ADDR_WDOG);
  assign guv     = q.s2[pdc_pkg::SY_GUV];
  assign slo_hit = q.s2[pdc_pkg::SY_SLO] & q.ctrl[pdc_pkg::CB_SLO_PROT];
  assign shi_hit = q.s2[pdc_pkg::SY_SHI] & q.ctrl[pdc_pkg::CB_SHI_PROT];
  assign bhi_hit = q.s2[pdc_pkg::SY_BHI] & q.ctrl[pdc_pkg::CB_BHI_HIZ];
  // Protection pulls the gates low; it never leaves a phase half driven.
  // Freewheeling must also drop the phase logic, or a gate would come
  // back on the moment the high-impedance state ends.
  assign drive_ok = (q.st == pdc_pkg::ST_NORM) & ~slo_hit & ~shi_hit &
                    ~bhi_hit;

  // Only the watchdog error is sticky; the rest show the live state, sync outputs and pin drives.
  always_comb
  begin
    stat = '0;
    stat[pdc_pkg::SB_STATE_LSB +: 3] = q.st;
    stat[pdc_pkg::SB_SLO]            = q.s2[pdc_pkg::SY_SLO];
    stat[pdc_pkg::SB_SHI]            = q.s2[pdc_pkg::SY_SHI];
    stat[pdc_pkg::SB_BHI]            = q.s2[pdc_pkg::SY_BHI];
    stat[pdc_pkg::SB_GUV]            = guv;
    stat[pdc_pkg::SB_WDERR]          = q.wd_err;
    stat[pdc_pkg::SB_HRST]           = q.hrst_drv;
    stat[pdc_pkg::SB_FAULT]          = q.fault_drv;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    n    = q;
    n.s1 = raw;
    n.s2 = q.s1;
    // A third flop makes the level echo a clean register output.
    n.pwm = q.s2[pdc_pkg::SY_PWM];

    unique case (q.st)
      pdc_pkg::ST_SLEEP:
      begin
        if (wake_s)
          n.st = pdc_pkg::ST_POR;
      end
      pdc_pkg::ST_POR:
      begin
        // Wake dropping before the core is good aborts the start-up.
        if (!wake_s)
          n.st = pdc_pkg::ST_SLEEP;
        else if (q.s2[pdc_pkg::SY_POR])
          n.st = pdc_pkg::ST_CFG;
      end
      pdc_pkg::ST_CFG:
      begin
        // One cycle of load: the configuration word must be steady by now.
        n.ctrl   = otp_cfg_in[7:0];
        n.dt_min = otp_cfg_in[pdc_pkg::OTP_DT_LSB +: 4];
        n.st     = pdc_pkg::ST_HOST;
      end
      pdc_pkg::ST_HOST:
      begin
        // The host reset is held here until the host supply is good.
        if (!wake_s)
          n.st = pdc_pkg::ST_SLEEP;
        else if (q.s2[pdc_pkg::SY_VCC])
          n.st = pdc_pkg::ST_STBY;
      end
      pdc_pkg::ST_STBY:
      begin
        // Enable is looked at first, so it wins over a falling wake line.
        if (en_s)
          n.st = pdc_pkg::ST_NORM;
        else if (!wake_s)
          n.st = pdc_pkg::ST_SLEEP;
      end
      pdc_pkg::ST_NORM:
      begin
        // A low wake line is not looked at here, so it waits for enable low.
        if (!en_s)
          n.st = pdc_pkg::ST_STBY;
      end
      // Codes four and five are unused; a flipped bit recovers via Sleep.
      default:
        n.st = pdc_pkg::ST_SLEEP;
    endcase

    // Sleep holds the configuration in its reset state.
    if (q.st == pdc_pkg::ST_SLEEP)
    begin
      n.ctrl   = pdc_pkg::CTRL_RST;
      n.dt_min = pdc_pkg::DT_RST;
      n.dt_dyn = pdc_pkg::DT_RST;
    end

    // Register bus: the answer is prepared in the setup cycle.
    if (setup)
    begin
      n.err = ~bus_ok | ~mapped;
      unique case (paddr)
        pdc_pkg::ADDR_CTRL: n.rdata = {24'h000000, q.ctrl};
        pdc_pkg::ADDR_DEAD: n.rdata = {20'h00000, q.dt_dyn, 4'h0, q.dt_min};
        pdc_pkg::ADDR_STAT: n.rdata = stat;
        default:            n.rdata = 32'h00000000;
      endcase
      // A refused access reads zero, so no register leaks out while asleep.
      if (n.err)
        n.rdata = 32'h00000000;
    end
    // The error flag taken in setup blocks the access, so a refused write never lands.
    if (wr && paddr == pdc_pkg::ADDR_CTRL)
    begin
      n.ctrl = pwdata[7:0];
      if (q.st == pdc_pkg::ST_NORM)
        n.ctrl[pdc_pkg::CB_MODE3] = q.ctrl[pdc_pkg::CB_MODE3];
    end
    if (wr && paddr == pdc_pkg::ADDR_DEAD)
    begin
      // A running count is left alone; new values apply from the next interval.
      n.dt_min = pwdata[pdc_pkg::DB_MIN_LSB +: 4];
      n.dt_dyn = pwdata[pdc_pkg::DB_DYN_LSB +: 4];
    end
    // The watchdog below sets the error after this clear, so a set wins.
    if (rd && paddr == pdc_pkg::ADDR_STAT)
      n.wd_err = 1'b0;

    // Watchdog: only the first open window is modelled; a service write
    // restarts it, expiry pulses the host reset for a fixed time.
    if (awake && q.ctrl[pdc_pkg::CB_WD_EN])
    begin
      n.wd_cnt = q.wd_cnt + 17'h00001;
      if (q.wd_rst)
      begin
        if (q.wd_cnt == pdc_pkg::WD_CW'(WD_RST_CYCLES - 1))
        begin
          n.wd_rst = 1'b0;
          n.wd_cnt = '0;
        end
      end
      else if (wr && paddr == pdc_pkg::ADDR_WDOG)
        n.wd_cnt = '0;
      else if (q.wd_cnt == pdc_pkg::WD_CW'(WD_FOW_CYCLES - 1))
      begin
        n.wd_rst = 1'b1;
        n.wd_err = 1'b1;
        n.wd_cnt = '0;
      end
    end
    else
    begin
      // Disabling the watchdog also ends a reset pulse that is running.
      n.wd_cnt = '0;
      n.wd_rst = 1'b0;
    end

    // Host reset stays low until the host supply is good, and again on
    // any dip below its threshold or a watchdog expiry.
    n.hrst_drv = ~awake | ~q.s2[pdc_pkg::SY_VCC] | n.wd_rst;

    // Gate undervoltage is masked until Standby is reached.
    n.fault_drv = awake & (guv | q.s2[pdc_pkg::SY_SLO] | q.s2[pdc_pkg::SY_SHI] |
                           q.s2[pdc_pkg::SY_BHI] | q.wd_err);

    // Bridge overvoltage freewheels the motor only if programmed to.
    n.hiz = (n.st == pdc_pkg::ST_SLEEP) | (awake & bhi_hit);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Reset looks like Sleep: host held in reset, gates released.
      q          <= '0;
      q.st       <= pdc_pkg::ST_SLEEP;
      q.ctrl     <= pdc_pkg::CTRL_RST;
      q.hrst_drv <= 1'b1;
      q.hiz      <= 1'b1;
    end
    else
      q <= n;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Three half-bridges share one decode and dead-time module.
  // Each reads the second sync flop, so all three see one sample.
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++)
    begin : g_phase
      pdc_phase u_phase (
        .clock    (clock),
        .arst_n   (arst_n),
        .drive_en (drive_ok),
        .mode3    (q.ctrl[pdc_pkg::CB_MODE3]),
        .hs_cmd   (q.s2[pdc_pkg::SY_HS + ph]),
        .ls_cmd   (q.s2[pdc_pkg::SY_LS + ph]),
        .dt_min   (q.dt_min),
        .dt_dyn   (q.dt_dyn),
        .gate_hi  (upper_gate_out[ph]),
        .gate_lo  (lower_gate_out[ph])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign prdata  = q.rdata;
  // Every register is a flop, so no access needs a wait state.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & q.err;

  assign core_regulator_out       = wake_s | (q.st != pdc_pkg::ST_SLEEP);
  assign osc_en_out               = (q.st != pdc_pkg::ST_SLEEP) && (q.st != pdc_pkg::ST_POR);
  assign host_supply_en_out       = (q.st == pdc_pkg::ST_HOST) | awake;
  assign gate_supply_rail         = (q.st == pdc_pkg::ST_HOST) | awake;
  assign serial_port_en_out       = bus_ok;
  assign host_supply_volt_select  = q.ctrl[pdc_pkg::CB_HOST_5V];
  assign gate_supply_level_select = q.ctrl[pdc_pkg::CB_GATE_LVL];
  // Both open-drain pins only pull low; the enable carries the level.
  assign host_reset_out           = 1'b0;
  assign host_reset_oe_n          = ~q.hrst_drv;
  assign fault_indicator_out      = 1'b0;
  assign fault_indicator_oe_n     = ~q.fault_drv;
  assign gates_hiz_out            = q.hiz;
  assign pwm_level_out            = q.pwm;

endmodule

// [verif/pdc_assertions.sv]
`timescale 1ns/1ps

module pdc_assertions #(
  parameter int unsigned WD_FOW_CYCLES = 40,
  parameter int unsigned WD_RST_CYCLES = 8
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr,
  input wire logic       drive_enable_in,
  input wire logic       host_supply_ok_in,
  input wire logic       core_regulator_out,
  input wire logic       osc_en_out,
  input wire logic       host_supply_en_out,
  input wire logic       gate_supply_rail,
  input wire logic       serial_port_en_out,
  input wire logic       host_reset_oe_n,
  input wire logic [2:0] upper_gate_out,
  input wire logic [2:0] lower_gate_out,
  input wire logic       gates_hiz_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sleep_gates_hiz_a: assert property (!core_regulator_out [*2] |-> gates_hiz_out)
    else $error("gates not released while asleep");
  hiz_gates_off_a: assert property (gates_hiz_out |-> !(|upper_gate_out) && !(|lower_gate_out))
    else $error("gate driven while high impedance");
  host_rst_held_a: assert property (!host_supply_en_out [*2] |-> !host_reset_oe_n)
    else $error("host reset released without host supply");
  host_rst_uv_a: assert property (!host_supply_ok_in [*5] |-> !host_reset_oe_n)
    else $error("host reset released on low host supply");
  stby_supplies_a: assert property (serial_port_en_out |-> host_supply_en_out && gate_supply_rail && osc_en_out)
    else $error("supplies off while serial port enabled");
  asleep_refused_a: assert property (psel && penable && !serial_port_en_out && !$past(serial_port_en_out)
    |-> pslverr)
    else $error("bus access accepted before standby");
  en_low_gates_a: assert property (!drive_enable_in [*5] |=> !(|upper_gate_out) && !(|lower_gate_out))
    else $error("gate on with drive enable low");
  no_overlap_a: assert property (!(|(upper_gate_out & lower_gate_out)))
    else $error("both gates of a phase on");
  // The bench loads a minimum dead time of 2, so an opposite gate stays off for 3 cycles.
  lo_dead_time_a: assert property ($fell(lower_gate_out[0]) |-> !upper_gate_out[0] [*3])
    else $error("upper gate on inside dead time");
  hi_dead_time_a: assert property ($fell(upper_gate_out[0]) |-> !lower_gate_out[0] [*3])
    else $error("lower gate on inside dead time");
endmodule

// [verif/pdc_host_model.sv]
`timescale 1ns/1ps

// Host controller: wake line, drive enable and phase commands.
module pdc_host_model (
  input  wire logic       clock,
  input  wire logic       braking,
  input  wire logic       bridge_warn,
  output logic            wake_in,
  output logic            drive_enable_in,
  output logic [2:0]      high_side_cmd_in,
  output logic [2:0]      low_side_cmd_in
);
  initial
  begin
    wake_in = 1'b0;
    drive_enable_in = 1'b0;
    high_side_cmd_in = 3'h0;
    low_side_cmd_in = 3'h0;
  end

  task automatic set_wake(input logic v);
    @(posedge clock);
    wake_in <= v;
  endtask

  task automatic set_enable(input logic v);
    @(posedge clock);
    drive_enable_in <= v;
  endtask

  task automatic set_phases(input logic [2:0] hs, input logic [2:0] ls);
    @(posedge clock);
    high_side_cmd_in <= hs;
    low_side_cmd_in <= ls;
  endtask

  // Freewheeling is unsafe while braking, so the host drops the stage itself.
  always @(posedge clock)
  begin
    if (braking && bridge_warn)
      drive_enable_in <= 1'b0;
  end
endmodule

// [verif/pdc_top_tb.sv]
`timescale 1ns/1ps

module pdc_top_tb;
  localparam int unsigned FOW = 40;
  localparam int unsigned RST = 8;
  // Dead-time minimum 2, host supply 5 V, logic-level gate supply.
  localparam logic [15:0] OTP = 16'h0203;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sense, host_ok, gate_uv, s_lo, s_hi, b_hi, hv_pwm, braking;
  logic        wake_in, drive_en;
  logic [2:0]  hs_cmd, ls_cmd, upper, lower;
  logic        core_reg, osc_en, host_en, gate_en, spi_en, vsel, gsel;
  logic        hrst, hrst_oe_n, flt, flt_oe_n, hiz, pwm_lvl;
  int          err_total, cmp_count;

  pdc_top #(.WD_FOW_CYCLES(FOW), .WD_RST_CYCLES(RST)) i_pdc_top (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_in(wake_in), .drive_enable_in(drive_en), .high_side_cmd_in(hs_cmd),
    .low_side_cmd_in(ls_cmd), .core_regulator_sense(sense), .host_supply_ok_in(host_ok),
    .gate_supply_low_in(gate_uv), .supply_low_in(s_lo), .supply_high_in(s_hi),
    .bridge_supply_high_in(b_hi), .high_voltage_pwm_in(hv_pwm), .otp_cfg_in(OTP),
    .core_regulator_out(core_reg), .osc_en_out(osc_en), .host_supply_en_out(host_en),
    .gate_supply_rail(gate_en), .serial_port_en_out(spi_en), .host_supply_volt_select(vsel),
    .gate_supply_level_select(gsel), .host_reset_out(hrst), .host_reset_oe_n(hrst_oe_n),
    .fault_indicator_out(flt), .fault_indicator_oe_n(flt_oe_n), .upper_gate_out(upper),
    .lower_gate_out(lower), .gates_hiz_out(hiz), .pwm_level_out(pwm_lvl)
  );

  pdc_host_model i_pdc_host_model (
    .clock(clock), .braking(braking), .bridge_warn(b_hi), .wake_in(wake_in),
    .drive_enable_in(drive_en), .high_side_cmd_in(hs_cmd), .low_side_cmd_in(ls_cmd)
  );

  always #20 clock = ~clock;

  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the run's time limit ends a wait for a slave that never raises pready.
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_sleep();
    chk1(hiz, 1'b1);
    chk1(spi_en, 1'b0);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    chk1(rd_err, 1'b1);
    check(rd, 32'h0);
  endtask

  task automatic t_wakeup();
    i_pdc_host_model.set_wake(1'b1);
    for (int i = 0; i < 20 && core_reg !== 1'b1; i++) @(posedge clock);
    chk1(core_reg, 1'b1);
    sense <= 1'b1;
    for (int i = 0; i < 20 && osc_en !== 1'b1; i++) @(posedge clock);
    chk1(osc_en, 1'b1);
    repeat (10) @(posedge clock);
    chk1(host_en, 1'b1);
    chk1(hrst_oe_n, 1'b0);
    chk1(flt_oe_n, 1'b1);
    host_ok <= 1'b1;
    for (int i = 0; i < 20 && spi_en !== 1'b1; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk1(hrst_oe_n, 1'b1);
    chk1(flt_oe_n, 1'b0);
    check({29'h0, hiz, upper[0], lower[0]}, 32'h0);
    check({29'h0, gate_en, hrst, flt}, 32'h4);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h87, 32'h86);
    apb(1'b0, pdc_pkg::ADDR_CTRL, 32'h0);
    check(rd, {24'h0, OTP[7:0]});
    chk1(vsel, OTP[1]);
    chk1(gsel, OTP[0]);
    apb(1'b0, 8'h10, 32'h0);
    chk1(rd_err, 1'b1);
    gate_uv <= 1'b0;
  endtask

  task automatic t_drive(input logic m3);
    logic [2:0] h, l, eu, el;
    apb(1'b1, pdc_pkg::ADDR_CTRL, {24'h0, OTP[7:3], m3, OTP[1:0]});
    i_pdc_host_model.set_enable(1'b1);
    for (int c = 0; c < 4; c++)
    begin
      for (int p = 0; p < 3; p++)
      begin
        h[p] = ((c + p) & 2) != 0;
        l[p] = ((c + p) & 1) != 0;
        eu[p] = h[p] & l[p];
        el[p] = m3 ? (l[p] & !h[p]) : (!h[p] & !l[p]);
      end
      i_pdc_host_model.set_phases(h, l);
      repeat (12) @(posedge clock);
      check({26'h0, upper, lower}, {26'h0, eu, el});
    end
    apb(1'b1, pdc_pkg::ADDR_CTRL, {24'h0, OTP[7:3], !m3, OTP[1:0]});
    apb(1'b0, pdc_pkg::ADDR_CTRL, 32'h0);
    check(rd, {24'h0, OTP[7:3], m3, OTP[1:0]});
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h7, 32'h7);
    i_pdc_host_model.set_enable(1'b0);
    repeat (8) @(posedge clock);
    check({26'h0, upper, lower}, 32'h0);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h7, 32'h6);
  endtask

  task automatic t_watchdog();
    apb(1'b1, pdc_pkg::ADDR_CTRL, {24'h0, OTP[7:4], 1'b1, OTP[2:0]});
    repeat (3)
    begin
      repeat (FOW / 2) @(posedge clock);
      apb(1'b1, pdc_pkg::ADDR_WDOG, 32'h1);
    end
    repeat (FOW - 4) @(posedge clock);
    chk1(hrst_oe_n, 1'b1);
    for (int i = 0; i < 12 && hrst_oe_n !== 1'b0; i++) @(posedge clock);
    chk1(hrst_oe_n, 1'b0);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h100, 32'h100);
    chk1(hrst_oe_n, 1'b0);
    repeat (RST + 4) @(posedge clock);
    chk1(hrst_oe_n, 1'b1);
    apb(1'b1, pdc_pkg::ADDR_CTRL, {24'h0, OTP[7:0]});
  endtask

  task automatic t_protect();
    apb(1'b1, pdc_pkg::ADDR_CTRL, {24'h0, OTP[7:0] | 8'h40});
    i_pdc_host_model.set_enable(1'b1);
    s_lo <= 1'b1;
    s_hi <= 1'b1;
    b_hi <= 1'b1;
    hv_pwm <= 1'b1;
    repeat (8) @(posedge clock);
    chk1(hiz, 1'b1);
    chk1(flt_oe_n, 1'b0);
    chk1(pwm_lvl, 1'b1);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h70, 32'h70);
    braking <= 1'b1;
    hv_pwm <= 1'b0;
    repeat (10) @(posedge clock);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h7, 32'h6);
    chk1(pwm_lvl, 1'b0);
    braking <= 1'b0;
    b_hi <= 1'b0;
    s_lo <= 1'b0;
    s_hi <= 1'b0;
    host_ok <= 1'b0;
    repeat (5) @(posedge clock);
    chk1(hrst_oe_n, 1'b0);
    host_ok <= 1'b1;
    repeat (5) @(posedge clock);
    chk1(hrst_oe_n, 1'b1);
  endtask

  task automatic t_shutdown();
    i_pdc_host_model.set_enable(1'b1);
    i_pdc_host_model.set_wake(1'b0);
    repeat (10) @(posedge clock);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h7, 32'h7);
    i_pdc_host_model.set_enable(1'b0);
    for (int i = 0; i < 20 && spi_en !== 1'b0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk1(hiz, 1'b1);
    apb(1'b0, pdc_pkg::ADDR_STAT, 32'h0);
    chk1(rd_err, 1'b1);
  endtask

  ////////////////////////////////////////
  initial
  begin
    {clock, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {sense, host_ok, s_lo, s_hi, b_hi, hv_pwm, braking} = '0;
    gate_uv = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_sleep();
    t_wakeup();
    t_drive(1'b0);
    t_drive(1'b1);
    t_watchdog();
    t_protect();
    t_shutdown();
    final_report();
  end

  // The whole run needs about 400 cycles; a hang ends well after that.
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    final_report();
  end
endmodule

bind pdc_top pdc_assertions #(
  .WD_FOW_CYCLES(WD_FOW_CYCLES),
  .WD_RST_CYCLES(WD_RST_CYCLES)
) i_pdc_assertions (
  .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pslverr(pslverr),
  .drive_enable_in(drive_enable_in), .host_supply_ok_in(host_supply_ok_in),
  .core_regulator_out(core_regulator_out), .osc_en_out(osc_en_out),
  .host_supply_en_out(host_supply_en_out), .gate_supply_rail(gate_supply_rail),
  .serial_port_en_out(serial_port_en_out), .host_reset_oe_n(host_reset_oe_n),
  .upper_gate_out(upper_gate_out), .lower_gate_out(lower_gate_out), .gates_hiz_out(gates_hiz_out)
);
